// file: src/quad_uart_host_bus_select_defines.vh
// Constants for the quad UART host bus front end
`ifndef QUAD_UART_HOST_BUS_SELECT_DEFINES_VH
`define QUAD_UART_HOST_BUS_SELECT_DEFINES_VH

// Pin vector layout after the input synchroniser
`define PIN_W        18
`define PIN_DATA_LO  0
`define PIN_DATA_HI  7
`define PIN_ADDR_LO  8
`define PIN_ADDR_HI  10
`define PIN_CSA      11
`define PIN_CSB      12
`define PIN_CSC      13
`define PIN_CSD      14
`define PIN_WR       15
`define PIN_RD       16
`define PIN_STYLE    17

// Idle level of the pins: strobes and selects high, rest low
`define PIN_IDLE     18'h1f800

// Strap level choosing the strobe style; low picks the r/w-line style
`define STYLE_STROBE 1'h1

// Read/write line levels in the r/w-line style
`define RW_READ      1'h1

// Single bit levels
`define BIT_LOW      1'h0
`define BIT_HIGH     1'h1

// Channel indices
`define CHAN_A       2'h0
`define CHAN_B       2'h1
`define CHAN_C       2'h2
`define CHAN_D       2'h3

`define BYTE_ZERO    8'h00
`define ADDR_ZERO    3'h0

`endif

// file: src/quad_uart_host_bus_select.v
// Host parallel bus front end of a four channel UART, two bus styles
//
// Operation
// R01 - Strobe style: read strobe fall starts read
// R02 - Fetched byte driven; host latches on rise
// R03 - Read/write-line style ignores read strobe
// R04 - Strobe style: write strobe fall begins write
// R05 - Write strobe rise stores bus byte
// R06 - Other style: write pin is r/w level
// R07 - Strobe style: first select picks channel A
// R08 - Other style: first select is chip select
// R09 - Strobe style: second select picks channel B
// R10 - Other style: second select is address 3
// R11 - Strobe style: third select picks channel C
// R12 - Other style: third select is address 4
// R13 - Fourth select picks D, else ignored
// R14 - Low address lines pick channel register
// R15 - Eight bit data bus, driven on reads
// R16 - Address 4,3 give channel index A-D
// R17 - Data bus released unless valid read
`timescale 1ns/1ps
`include "quad_uart_host_bus_select_defines.vh"

module quad_uart_host_bus_select (
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       busStyle,
  input  wire       host_read_strobe_n,
  input  wire       host_write_strobe_n,
  input  wire       chan_a_select_n,
  input  wire       chan_b_select_n,
  input  wire       chan_c_select_n,
  input  wire       chan_d_select_n,
  input  wire [2:0] hostAddr,
  input  wire [7:0] hostDataIn,
  output reg  [7:0] hostDataOut,
  output reg        hostDataOe,
  output reg        regRead,
  output reg        regWrite,
  output reg  [1:0] regChannel,
  output reg  [2:0] regAddr,
  output reg  [7:0] regWriteData,
  input  wire [7:0] regReadData
);

  // ==========================================================
  // Pin synchroniser
  // ==========================================================
  // Three stages; a bit only moves once stages two and three agree,
  // which also filters a single-cycle glitch on the pins.
  // The strap takes the same path; it is meant to be tied, so a
  // change while an access is open is not guarded against.
  wire [`PIN_W-1:0] pinRaw;
  reg  [`PIN_W-1:0] sync1;
  reg  [`PIN_W-1:0] sync2;
  reg  [`PIN_W-1:0] sync3;
  wire [`PIN_W-1:0] pin;

  assign pinRaw = {busStyle, host_read_strobe_n, host_write_strobe_n,
                   chan_d_select_n, chan_c_select_n, chan_b_select_n,
                   chan_a_select_n, hostAddr, hostDataIn};

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= `PIN_IDLE;
      sync2 <= `PIN_IDLE;
      sync3 <= `PIN_IDLE;
    end else begin
      sync1 <= pinRaw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Reset image of the pins, one bit per filter
  localparam [`PIN_W-1:0] PIN_IDLE_V = `PIN_IDLE;

  genvar i;
  generate
    for (i = 0; i < `PIN_W; i = i + 1) begin : gFilter
      reg level;
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          level <= PIN_IDLE_V[i];
        end else if (sync2[i] == sync3[i]) begin
          level <= sync3[i];
        end
      end
      assign pin[i] = level;
    end
  endgenerate

  // ==========================================================
  // Channel decode
  // ==========================================================
  // Returns {selected, index}. Strobe style: lowest active select
  // wins if the host drives more than one.
  function [2:0] chanDecode;
    input       style;
    input [3:0] selN;
    begin
      if (style == `STYLE_STROBE) begin
        if (!selN[0])
          chanDecode = {`BIT_HIGH, `CHAN_A}; // R07
        else if (!selN[1])
          chanDecode = {`BIT_HIGH, `CHAN_B}; // R09
        else if (!selN[2])
          chanDecode = {`BIT_HIGH, `CHAN_C}; // R11
        else if (!selN[3])
          chanDecode = {`BIT_HIGH, `CHAN_D}; // R13
        else
          chanDecode = {`BIT_LOW, `CHAN_A};
      end else begin
        // Fourth select plays no part here
        chanDecode = {~selN[0], selN[2], selN[1]}; // R08 R10 R12 R13 R16
      end
    end
  endfunction

  wire       style;
  wire [3:0] selN;
  wire [2:0] chanSel;
  wire       selected;
  wire       readReq;
  wire       writeReq;

  assign style    = pin[`PIN_STYLE];
  assign selN     = {pin[`PIN_CSD], pin[`PIN_CSC], pin[`PIN_CSB],
                     pin[`PIN_CSA]};
  assign chanSel  = chanDecode(style, selN);
  assign selected = chanSel[2];

  // Access levels; read strobe unused in r/w-line style
  assign readReq  = (style == `STYLE_STROBE) ?
                    (!pin[`PIN_RD] && selected) :            // R01 R03
                    (selected && pin[`PIN_WR] == `RW_READ);   // R06
  assign writeReq = (style == `STYLE_STROBE) ?
                    (!pin[`PIN_WR] && selected) :            // R04
                    (selected && pin[`PIN_WR] != `RW_READ);   // R06

  // ==========================================================
  // Access sequencing
  // ==========================================================
  // Access levels rise and fall once per access; edges found here
  reg        readPrev;
  reg        writePrev;
  reg        readFetch;
  wire       readOpen;
  wire       writeClose;
  wire [2:0] pinAddr;
  wire [7:0] pinData;

  assign readOpen   = readReq && !readPrev;                  // R01
  assign writeClose = writePrev && !writeReq;                // R05
  assign pinAddr    = pin[`PIN_ADDR_HI:`PIN_ADDR_LO];
  assign pinData    = pin[`PIN_DATA_HI:`PIN_DATA_LO];

  // Request history; each access yields exactly one strobe
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      readPrev  <= `BIT_LOW;
      writePrev <= `BIT_LOW;
      readFetch <= `BIT_LOW;
      regRead   <= `BIT_LOW;
      regWrite  <= `BIT_LOW;
    end else begin
      readPrev  <= readReq;
      writePrev <= writeReq;
      regRead   <= readOpen;                                 // R01
      readFetch <= regRead;
      regWrite  <= writeClose;                               // R05
    end
  end

  // ==========================================================
  // Register target and write byte
  // ==========================================================
  // Read target is latched at read start. A write tracks target and
  // data while open, so the byte stored is the last one seen before
  // the closing edge; the host only holds data up to that edge.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regChannel   <= `CHAN_A;
      regAddr      <= `ADDR_ZERO;
      regWriteData <= `BYTE_ZERO;
    end else begin
      if (readOpen || writeReq) begin
        regChannel <= chanSel[1:0];                          // R07 R16
        regAddr    <= pinAddr;                               // R14
      end
      if (writeReq) begin
        regWriteData <= pinData;                             // R05 R15
      end
    end
  end

  // ==========================================================
  // Data bus drive
  // ==========================================================
  // Byte fetched in the strobe cycle; the bus turns on a cycle later
  // so the pads never show a stale byte.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hostDataOut <= `BYTE_ZERO;
    end else if (regRead) begin
      hostDataOut <= regReadData;                            // R02
    end
  end

  // Drive only while a selected read stays open
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hostDataOe <= `BIT_LOW;
    end else if (!readReq) begin
      hostDataOe <= `BIT_LOW;                                // R17
    end else if (readFetch) begin
      hostDataOe <= `BIT_HIGH;                               // R02 R15
    end
  end

endmodule

// file: dv/quad_uart_host_bus_select_sva.sv
// Checker for the host bus front end
`timescale 1ns/1ps
module quad_uart_host_bus_select_sva (
  input wire       ref_clk,
  input wire       resetn,
  input wire [7:0] hostDataOut,
  input wire       hostDataOe,
  input wire       regRead,
  input wire       regWrite
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_RD1: assert property (regRead |=> !regRead) else $error("rd");
  AST_WR1: assert property (regWrite |=> !regWrite) else $error("wr");
  AST_EXC: assert property (!(regRead && regWrite)) else $error("rw");
  AST_OEL: assert property (
    $rose(hostDataOe) |-> $past(regRead, 2)) else $error("oe");
  AST_OEN: assert property (regRead |=> !hostDataOe) else $error("oe");
  AST_OED: assert property (
    $rose(hostDataOe) |-> $stable(hostDataOut)) else $error("dat");
  AST_IDL: assert property (regRead |-> !hostDataOe) else $error("bus");
  AST_RST: assert property (
    $rose(resetn) |-> !hostDataOe && !regRead) else $error("rst");
endmodule
bind quad_uart_host_bus_select quad_uart_host_bus_select_sva chk (
  .ref_clk(ref_clk), .resetn(resetn), .hostDataOut(hostDataOut),
  .hostDataOe(hostDataOe), .regRead(regRead), .regWrite(regWrite));

// file: dv/host_bus_model.sv
// Host processor model driving the parallel bus
`timescale 1ns/1ps
module host_bus_model (
  input  wire       ref_clk,
  input  wire       busStyle,
  input  wire [7:0] hostDataOut,
  output reg        rdN = 1'b1,
  output reg        wrN = 1'b1,
  output reg  [3:0] selN = 4'hf,
  output reg  [2:0] addr = 3'h0,
  output reg  [7:0] dataIn = 8'h00,
  output reg  [7:0] captured = 8'h00
);
  // Held 10 cycles: input filter needs 4 edges
  task access(input rd, input [1:0] ch, input [7:0] wd);
    begin
      @(posedge ref_clk);
      addr <= {1'b1, ch};
      selN <= busStyle ? ~(4'h1 << ch) : {1'b0, ch, 1'b0};
      wrN <= rd;
      rdN <= busStyle ? !rd : 1'b0;
      dataIn <= rd ? ~dataIn : wd;
      repeat (10) @(posedge ref_clk);
      captured <= hostDataOut;
      rdN <= 1'b1;
      wrN <= 1'b1;
      selN <= 4'hf;
      dataIn <= ~dataIn;
      repeat (6) @(posedge ref_clk);
    end
  endtask
  // Strobes with every select high: no access may open
  task unselected(input rd);
    begin
      @(posedge ref_clk);
      wrN <= rd;
      rdN <= busStyle ? !rd : 1'b0;
      repeat (10) @(posedge ref_clk);
      rdN <= 1'b1;
      wrN <= 1'b1;
      repeat (6) @(posedge ref_clk);
    end
  endtask
endmodule

// file: dv/quad_uart_host_bus_select_tb.sv
// Self-checking bench for the host bus front end
`timescale 1ns/1ps
module quad_uart_host_bus_select_tb;
  reg ref_clk = 1'b0, resetn = 1'b0, busStyle = 1'b1;
  reg [7:0] regReadData = 8'h00, wrByte = 8'h00;
  reg [4:0] rdSeen = 5'h00, wrSeen = 5'h00;
  reg [3:0] rdCnt = 4'h0, wrCnt = 4'h0;
  reg [7:0] oeCyc = 8'h00;
  wire rdN, wrN, hostDataOe, regRead, regWrite;
  wire [3:0] selN;
  wire [2:0] addr, regAddr;
  wire [1:0] regChannel;
  wire [7:0] dataIn, hostDataOut, regWriteData, captured;
  int fails = 0;
  int tests_run = 0;
  always #4 ref_clk = ~ref_clk;
  quad_uart_host_bus_select DUT (.ref_clk(ref_clk), .resetn(resetn),
    .busStyle(busStyle), .host_read_strobe_n(rdN),
    .host_write_strobe_n(wrN), .chan_a_select_n(selN[0]),
    .chan_b_select_n(selN[1]), .chan_c_select_n(selN[2]),
    .chan_d_select_n(selN[3]), .hostAddr(addr), .hostDataIn(dataIn),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .regRead(regRead),
    .regWrite(regWrite), .regChannel(regChannel), .regAddr(regAddr),
    .regWriteData(regWriteData), .regReadData(regReadData));
  host_bus_model host (.ref_clk(ref_clk), .busStyle(busStyle),
    .hostDataOut(hostDataOut), .rdN(rdN), .wrN(wrN), .selN(selN),
    .addr(addr), .dataIn(dataIn), .captured(captured));
  always @(posedge ref_clk) begin
    if (regRead) begin
      rdSeen <= {regChannel, regAddr};
      rdCnt <= rdCnt + 4'h1;
    end
    if (hostDataOe) oeCyc <= oeCyc + 8'h01;
    if (regWrite) begin
      wrSeen <= {regChannel, regAddr};
      wrByte <= regWriteData;
      wrCnt <= wrCnt + 4'h1;
    end
  end
  task check(input [7:0] got, input [7:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        fails++;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task run_one(input rd, input [1:0] ch);
    reg [3:0] r0, w0;
    reg [7:0] v, o0;
    begin
      r0 = rdCnt;
      w0 = wrCnt;
      o0 = oeCyc;
      v = {ch, 5'h16, rd};
      @(posedge ref_clk) regReadData <= v;
      host.access(rd, ch, ~v);
      @(negedge ref_clk);
      check({3'h0, rd ? rdSeen : wrSeen}, {3'h0, ch, 1'b1, ch});
      check(rd ? captured : wrByte, rd ? v : ~v);
      check({rdCnt - r0, wrCnt - w0}, {3'h0, rd, 3'h0, !rd});
      check({7'h0, oeCyc != o0}, {7'h0, rd});
      check({7'h0, hostDataOe}, 8'h00);
    end
  endtask
  // Strobes with no select open nothing and leave the bus alone
  task no_select(input rd);
    reg [3:0] r0, w0;
    reg [7:0] o0;
    begin
      r0 = rdCnt;
      w0 = wrCnt;
      o0 = oeCyc;
      host.unselected(rd);
      @(negedge ref_clk);
      check({rdCnt - r0, wrCnt - w0}, 8'h00);
      check({7'h0, oeCyc != o0}, 8'h00);
    end
  endtask
  // Each channel read and written in both bus styles
  task both_styles;
    begin
      for (int c = 0; c < 4; c++) begin
        run_one(1'b1, c[1:0]);
        run_one(1'b0, c[1:0]);
      end
      no_select(1'b1);
      no_select(1'b0);
      @(posedge ref_clk) busStyle <= 1'b0;
      repeat (8) @(posedge ref_clk);
      for (int c = 0; c < 4; c++) begin
        run_one(1'b1, c[1:0]);
        run_one(1'b0, c[1:0]);
      end
      no_select(1'b1);
      no_select(1'b0);
    end
  endtask
  task report_and_stop;
    begin
      $display("Checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    both_styles;
    report_and_stop;
  end
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
endmodule
